// ### clkcfg_regs.svh
// register bank constants: byte indices, field positions, power-up values
// assumes inclusion by bare name from the receiver and bank modules
`ifndef CLKCFG_REGS_SVH
`define CLKCFG_REGS_SVH
`define CLKCFG_SLAVE_ADDR 7'h69
`define CLKCFG_CMD_CODE 8'h00
`define CLKCFG_NUM_BYTES 7
`define CLKCFG_IDX_SPREAD 3'h0
`define CLKCFG_IDX_CPU 3'h1
`define CLKCFG_IDX_BUS 3'h2
`define CLKCFG_IDX_FREE 3'h3
`define CLKCFG_IDX_S66 3'h4
`define CLKCFG_IDX_DELAY 3'h5
`define CLKCFG_IDX_ID 3'h6
`define CLKCFG_RST_SPREAD 8'h19
`define CLKCFG_RST_CPU 8'h47
`define CLKCFG_RST_BUS 8'h7f
`define CLKCFG_RST_FREE 8'hc7
`define CLKCFG_RST_S66 8'h3f
`define CLKCFG_RST_DELAY 8'h00
`define CLKCFG_WMASK_SPREAD 8'ha8
`define CLKCFG_WMASK_CPU 8'h7f
`define CLKCFG_WMASK_BUS 8'h7f
`define CLKCFG_WMASK_FREE 8'hff
`define CLKCFG_WMASK_S66 8'h3f
`define CLKCFG_WMASK_DELAY 8'h3f
`define CLKCFG_BIT_SPREAD 7
`define CLKCFG_BIT_SEL48 5
`define CLKCFG_BIT_BUSRUN 3
`define CLKCFG_BIT_MODE 2
`define CLKCFG_BIT_FSEL 1
`define CLKCFG_BIT_MULT 7
`endif

// ### clkcfg_pkg.sv
// types shared by the configuration bank and its link receiver
// assumes clkcfg_regs.svh supplies the numeric constants
package clkcfg_pkg;
   // one received data byte with its register index
   typedef struct packed {
      logic [2:0] idx;
      logic [7:0] data;
   } clkcfg_wr_t;
   // decoded clock control outputs
   typedef struct packed {
      logic spread_on;
      logic sel_48;
      logic bus_run;
      logic [3:0] cpu_en;
      logic [6:0] bus_en;
      logic display_48_en;
      logic host_48_en;
      logic [2:0] free_stoppable;
      logic [2:0] free_en;
      logic first_66_en;
      logic selectable_66_48_en;
      logic dual_role_66_en;
      logic [2:0] buffered_66_en;
      logic [1:0] prop_delay;
      logic [1:0] display_edge;
      logic [1:0] host_edge;
   } clkcfg_ctl_t;
endpackage : clkcfg_pkg

// ### clkcfg_sync.sv
// two-flop level synchroniser, parameter width
// assumes destination clock and synchronous reset
`timescale 1ns/1ps
module clkcfg_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_ff;
   // first stage is read only by the second stage
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_ff <= '0;
         q_out <= '0;
      end else begin
         meta_ff <= d_in;
         q_out <= meta_ff;
      end
   end
endmodule : clkcfg_sync

// ### clkcfg_smbus_rx.sv
// smbus block-write receiver, runs on the smbus clock itself
// assumes data is sampled on scl rising edges; start seen via a
// data fall while scl high, which needs a flop clocked by sda itself
`timescale 1ns/1ps
module clkcfg_smbus_rx
   import clkcfg_pkg::*;
#(
   parameter int MAX_COUNT = 32
) (
   input wire logic scl_in,
   input wire logic rst_in,
   input wire logic sda_in,
   input wire logic start_in,
   output logic sda_oe_out,
   output logic wr_tog_out,
   output clkcfg_wr_t wr_out
);
`include "clkcfg_regs.svh"
   typedef enum {S_ADDR, S_CMD, S_COUNT, S_DATA, S_IGNORE} clkcfg_rx_st_t;
   clkcfg_rx_st_t st_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [5:0] left_ff;
   logic [2:0] idx_ff;
   logic ack_ff;
   logic [7:0] byte_w;
   assign byte_w = {sh_ff[6:0], sda_in};
   // bit counter: 8 data bits then one acknowledge slot
   always_ff @(posedge scl_in) begin
      if (rst_in) begin
         bit_ff <= 4'h0;
      end else if (start_in) begin
         // the first rise after a start already carries the top bit
         bit_ff <= 4'h1;
      end else if (bit_ff == 4'h8) begin
         bit_ff <= 4'h0;
      end else begin
         bit_ff <= bit_ff + 4'h1;
      end
   end
   // shift in msb first
   always_ff @(posedge scl_in) begin
      if (rst_in) begin
         sh_ff <= 8'h00;
      end else if (start_in || (bit_ff < 4'h8)) begin
         sh_ff <= byte_w;
      end
   end
   // byte level protocol
   always_ff @(posedge scl_in) begin
      if (rst_in || start_in) begin
         st_ff <= S_ADDR;
         ack_ff <= 1'b0;
         left_ff <= 6'h00;
         idx_ff <= 3'h0;
         wr_tog_out <= wr_tog_out & ~rst_in;
         wr_out <= '0;
      end else if (bit_ff == 4'h7) begin
         ack_ff <= 1'b0;
         case (st_ff)
            S_ADDR: begin
               // only our address with write direction is answered
               if (byte_w == {`CLKCFG_SLAVE_ADDR, 1'b0}) begin
                  st_ff <= S_CMD;
                  ack_ff <= 1'b1;
               end else begin
                  st_ff <= S_IGNORE;
               end
            end
            S_CMD: begin
               st_ff <= (byte_w == `CLKCFG_CMD_CODE) ? S_COUNT : S_IGNORE;
               ack_ff <= (byte_w == `CLKCFG_CMD_CODE);
            end
            S_COUNT: begin
               // a zero or oversize count is not acknowledged
               if (byte_w != 8'h00 && byte_w <= 8'(MAX_COUNT)) begin
                  st_ff <= S_DATA;
                  ack_ff <= 1'b1;
                  left_ff <= byte_w[5:0];
                  idx_ff <= 3'h0;
               end else begin
                  st_ff <= S_IGNORE;
               end
            end
            S_DATA: begin
               if (left_ff != 6'h00) begin
                  ack_ff <= 1'b1;
                  left_ff <= left_ff - 6'h01;
                  // bytes past the bank are acked and dropped
                  if (idx_ff < 3'(`CLKCFG_NUM_BYTES)) begin
                     wr_out <= '{idx: idx_ff, data: byte_w};
                     wr_tog_out <= ~wr_tog_out;
                     idx_ff <= idx_ff + 3'h1;
                  end
               end
            end
            default: begin
               st_ff <= S_IGNORE;
            end
         endcase
      end
   end
   // acknowledge request; the pin flop in the bank registers it on the
   // falling edge, so a second flop here would miss the ninth rise
   assign sda_oe_out = ack_ff && (bit_ff == 4'h8) && !rst_in;
endmodule : clkcfg_smbus_rx

// ### clkcfg_bank.sv
// configuration register bank of the clock synthesizer
// assumes RESET_IN marks power-up and straps are valid at its release;
// the smbus link has its own clock domain, the smbus clock pin
//
// Notes on behaviour
// - byte 0 bit 7 turns spread spectrum on; power-up off
// - byte 0 bit 5 selects 48 MHz on shared output; power-up 66 MHz
// - byte 0 bit 3 stops the seven stoppable bus clocks when 0; power-up 1
// - byte 0 bits 2,1 read straps captured at power-up, read only
// - byte 1 bits 6,2,1,0 enable processor pairs 3..0; power-up 1
// - byte 2 bits 6..0 enable stoppable bus clocks; bit 7 reads 0
// - byte 3 bits 7,6 enable display and host 48 MHz outputs
// - byte 3 bits 5..3 let stop pin halt free bus clocks 2..0
// - byte 3 bits 2..0 enable free-running bus clocks; power-up 1
// - byte 4 bits 5,4 enable first 66 and shared output; 7,6 read 0
// - byte 4 bit 3 enables the dual-role pin as 66 MHz output
// - byte 4 bits 2..0 enable buffered 66 outputs; power-up 1
// - byte 5 bits 5,4 set buffered propagation delay; 7,6 read 0
// - byte 5 bits 3,2 and 1,0 set display and host edge rates
// - writes are smbus block writes to our address, direction 0
// - data fills bytes from zero upward, msb first, may stop anywhere
`timescale 1ns/1ps
module clkcfg_bank
   import clkcfg_pkg::*;
#(
   parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
   parameter logic [3:0] VENDOR_CODE = 4'h5 // arbitrary value
) (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic SMB_CLK_IN,
   input wire logic SMB_DATA_IN,
   output logic SMB_DATA_OUT,
   output logic SMB_DATA_OE_OUT,
   input wire logic TRI_LEVEL_MODE_STRAP_IN,
   input wire logic FREQUENCY_SELECT_STRAP_IN,
   input wire logic CURRENT_MULTIPLIER_STRAP_IN,
   input wire logic [2:0] READ_IDX_IN,
   output logic [7:0] READ_DATA_OUT,
   output clkcfg_ctl_t CTL_OUT
);
`include "clkcfg_regs.svh"
   logic [7:0] regs_ff [0:`CLKCFG_NUM_BYTES-2];
   logic [2:0] strap_sync;
   logic [2:0] strap_ff;
   logic strap_taken_ff;
   logic rst_smb_meta_ff;
   logic rst_smb_ff;
   logic start_ff;
   logic start_clr_ff;
   logic wr_tog;
   clkcfg_wr_t wr_smb;
   logic wr_tog_sync;
   logic wr_tog_seen_ff;
   clkcfg_wr_t wr_word;
   logic [7:0] nxt_read;
   logic ack_oe;

   // straps pass two flops before capture; kept out of reset so the
   // capture at release sees the pin levels, not cleared stages
   clkcfg_sync #(.WIDTH(3)) u_strap_sync (
      .clk_in(CLK_SYS_IN),
      .rst_in(1'b0),
      .d_in({TRI_LEVEL_MODE_STRAP_IN, FREQUENCY_SELECT_STRAP_IN,
             CURRENT_MULTIPLIER_STRAP_IN}),
      .q_out(strap_sync)
   );

   // capture straps once after reset release, then hold them
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         strap_ff <= 3'h0;
         strap_taken_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         strap_ff <= strap_sync;
         strap_taken_ff <= 1'b1;
      end
   end

   // reset carried into the link domain; link clock may idle, so it only
   // takes effect on the second link edge, which is before any byte lands
   always_ff @(posedge SMB_CLK_IN) begin
      rst_smb_meta_ff <= RESET_IN;
      rst_smb_ff <= rst_smb_meta_ff;
   end

   // start condition: data falls while link clock high
   always_ff @(negedge SMB_DATA_IN or posedge rst_smb_ff) begin
      if (rst_smb_ff) begin
         start_ff <= 1'b0;
      end else if (SMB_CLK_IN) begin
         start_ff <= ~start_clr_ff;
      end else begin
         start_ff <= start_clr_ff;
      end
   end
   // start handshake toggles against the clear side on the next rise
   always_ff @(posedge SMB_CLK_IN) begin
      if (rst_smb_ff) begin
         start_clr_ff <= 1'b0;
      end else begin
         start_clr_ff <= start_ff;
      end
   end

   clkcfg_smbus_rx #(.MAX_COUNT(32)) u_rx (
      .scl_in(SMB_CLK_IN),
      .rst_in(rst_smb_ff),
      .sda_in(SMB_DATA_IN),
      .start_in(start_ff ^ start_clr_ff),
      .sda_oe_out(ack_oe),
      .wr_tog_out(wr_tog),
      .wr_out(wr_smb)
   );

   // only the toggle crosses through flops; the word changes at the same
   // link edge and then holds for a whole byte, so it is read as it stands
   clkcfg_sync #(.WIDTH(1)) u_wr_sync (
      .clk_in(CLK_SYS_IN),
      .rst_in(RESET_IN),
      .d_in(wr_tog),
      .q_out(wr_tog_sync)
   );
   assign wr_word = wr_smb;

   // toggle edge marks a new byte; data was stable a cycle earlier
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         wr_tog_seen_ff <= 1'b0;
      end else begin
         wr_tog_seen_ff <= wr_tog_sync;
      end
   end

   // writable registers, only write-mask bits change; byte 1 mask also opens bits 5..3
   generate
      for (genvar i = 0; i < `CLKCFG_NUM_BYTES - 1; i++) begin : g_reg
         localparam logic [7:0] RST_V = (i == 0) ? `CLKCFG_RST_SPREAD :
                                        (i == 1) ? `CLKCFG_RST_CPU :
                                        (i == 2) ? `CLKCFG_RST_BUS :
                                        (i == 3) ? `CLKCFG_RST_FREE :
                                        (i == 4) ? `CLKCFG_RST_S66 :
                                        `CLKCFG_RST_DELAY;
         localparam logic [7:0] WM = (i == 0) ? `CLKCFG_WMASK_SPREAD :
                                     (i == 1) ? `CLKCFG_WMASK_CPU :
                                     (i == 2) ? `CLKCFG_WMASK_BUS :
                                     (i == 3) ? `CLKCFG_WMASK_FREE :
                                     (i == 4) ? `CLKCFG_WMASK_S66 :
                                     `CLKCFG_WMASK_DELAY;
         always_ff @(posedge CLK_SYS_IN) begin
            if (RESET_IN) begin
               regs_ff[i] <= RST_V;
            end else if ((wr_tog_sync != wr_tog_seen_ff) && (wr_word.idx == 3'(i))) begin
               regs_ff[i] <= (regs_ff[i] & ~WM) | (wr_word.data & WM);
            end
         end
      end
   endgenerate

   // read mux; read-only fields come from straps and fixed codes
   always_comb begin
      nxt_read = 8'h00;
      case (READ_IDX_IN)
         `CLKCFG_IDX_SPREAD: begin
            nxt_read = regs_ff[0];
            nxt_read[`CLKCFG_BIT_MODE] = strap_ff[2];
            nxt_read[`CLKCFG_BIT_FSEL] = strap_ff[1];
         end
         `CLKCFG_IDX_CPU: begin
            nxt_read = regs_ff[1];
            nxt_read[`CLKCFG_BIT_MULT] = strap_ff[0];
         end
         `CLKCFG_IDX_BUS: nxt_read = regs_ff[2];
         `CLKCFG_IDX_FREE: nxt_read = regs_ff[3];
         `CLKCFG_IDX_S66: nxt_read = regs_ff[4];
         `CLKCFG_IDX_DELAY: nxt_read = regs_ff[5];
         `CLKCFG_IDX_ID: nxt_read = {REVISION_CODE, VENDOR_CODE};
         default: nxt_read = 8'h00;
      endcase
   end

   // registered outputs
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         READ_DATA_OUT <= 8'h00;
      end else begin
         READ_DATA_OUT <= nxt_read;
      end
   end

   // control decode from register bytes
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         CTL_OUT <= '0;
      end else begin
         CTL_OUT.spread_on <= regs_ff[0][`CLKCFG_BIT_SPREAD];
         CTL_OUT.sel_48 <= regs_ff[0][`CLKCFG_BIT_SEL48];
         CTL_OUT.bus_run <= regs_ff[0][`CLKCFG_BIT_BUSRUN];
         CTL_OUT.cpu_en <= {regs_ff[1][6], regs_ff[1][2:0]};
         CTL_OUT.bus_en <= regs_ff[2][6:0];
         CTL_OUT.display_48_en <= regs_ff[3][7];
         CTL_OUT.host_48_en <= regs_ff[3][6];
         CTL_OUT.free_stoppable <= regs_ff[3][5:3];
         CTL_OUT.free_en <= regs_ff[3][2:0];
         CTL_OUT.first_66_en <= regs_ff[4][5];
         CTL_OUT.selectable_66_48_en <= regs_ff[4][4];
         CTL_OUT.dual_role_66_en <= regs_ff[4][3];
         CTL_OUT.buffered_66_en <= regs_ff[4][2:0];
         CTL_OUT.prop_delay <= regs_ff[5][5:4];
         CTL_OUT.display_edge <= regs_ff[5][3:2];
         CTL_OUT.host_edge <= regs_ff[5][1:0];
      end
   end

   // open-drain data: only ever pulls low
   always_ff @(negedge SMB_CLK_IN) begin
      SMB_DATA_OUT <= 1'b0;
      SMB_DATA_OE_OUT <= ack_oe & ~rst_smb_ff;
   end
endmodule : clkcfg_bank

// ### clkcfg_bank_properties.sv
// port checker for the configuration bank
// assumes binding onto clkcfg_bank; read-back and control outputs lag alike
`timescale 1ns/1ps
module clkcfg_bank_chk
   import clkcfg_pkg::*;
#(
   parameter logic [3:0] REVISION_CODE = 4'h3,
   parameter logic [3:0] VENDOR_CODE = 4'h5
) (
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic SMB_CLK_IN,
   input wire logic SMB_DATA_OE_OUT,
   input wire logic [2:0] READ_IDX_IN,
   input wire logic [7:0] READ_DATA_OUT,
   input wire clkcfg_ctl_t CTL_OUT
);
   localparam clkcfg_ctl_t CTL_DEF = {3'b001, 4'hf, 7'h7f, 2'b11, 3'h0, 3'h7, 3'b111, 3'h7, 6'h0};
   logic [1:0] up_cnt_ff;
   logic live;
   logic [7:0] rd;
   clkcfg_ctl_t c;
   // settle window: straps and defaults land a few edges after release
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN)
         up_cnt_ff <= 2'h0;
      else if (up_cnt_ff != 2'h3)
         up_cnt_ff <= up_cnt_ff + 2'h1;
   end
   assign live = (up_cnt_ff == 2'h3);
   assign rd = READ_DATA_OUT;
   assign c = CTL_OUT;
   property p_byte0;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h0 |-> {rd[7], rd[5], rd[3]} == {c.spread_on, c.sel_48, c.bus_run};
   endproperty
   a_byte0: assert property (p_byte0) else $error("byte 0 fields differ");
   property p_strap;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h0 && $past(READ_IDX_IN, 2) == 3'h0
         |-> $stable(rd[2:1]) && rd[4] && rd[0] && !rd[6];
   endproperty
   a_strap: assert property (p_strap) else $error("strap bits moved");
   property p_cpu;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h1 |-> rd[6:0] == {c.cpu_en[3], 3'h0, c.cpu_en[2:0]};
   endproperty
   a_cpu: assert property (p_cpu) else $error("byte 1 fields differ");
   property p_bus;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h2 |-> rd == {1'b0, c.bus_en};
   endproperty
   a_bus: assert property (p_bus) else $error("byte 2 fields differ");
   property p_free;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h3
         |-> rd == {c.display_48_en, c.host_48_en, c.free_stoppable, c.free_en};
   endproperty
   a_free: assert property (p_free) else $error("byte 3 fields differ");
   property p_s66;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h4 |-> rd == {2'b00, c.first_66_en,
         c.selectable_66_48_en, c.dual_role_66_en, c.buffered_66_en};
   endproperty
   a_s66: assert property (p_s66) else $error("byte 4 fields differ");
   property p_delay;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h5 |-> rd == {2'b00, c.prop_delay, c.display_edge, c.host_edge};
   endproperty
   a_delay: assert property (p_delay) else $error("byte 5 fields differ");
   property p_ident;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      live && $past(READ_IDX_IN) == 3'h6 |-> rd == {REVISION_CODE, VENDOR_CODE};
   endproperty
   a_ident: assert property (p_ident) else $error("identification byte wrong");
   property p_defaults;
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      $fell(RESET_IN) |=> CTL_OUT == CTL_DEF;
   endproperty
   a_defaults: assert property (p_defaults) else $error("power-up controls wrong");
   property p_ack_len;
      @(negedge SMB_CLK_IN) disable iff (RESET_IN)
      $rose(SMB_DATA_OE_OUT) |=> !SMB_DATA_OE_OUT;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("ack not one bit long");
endmodule : clkcfg_bank_chk
bind clkcfg_bank clkcfg_bank_chk #(.REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE)) chk_u (
   .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .SMB_CLK_IN(SMB_CLK_IN),
   .SMB_DATA_OE_OUT(SMB_DATA_OE_OUT), .READ_IDX_IN(READ_IDX_IN),
   .READ_DATA_OUT(READ_DATA_OUT), .CTL_OUT(CTL_OUT));

// ### clkcfg_host_model.sv
// smbus host model issuing block writes
// assumes a pull-up on data; clock stands high between frames
`timescale 1ns/1ps
module clkcfg_host_model (
   output logic scl_out,
   output logic sda_out,
   input wire logic sda_in
);
   logic [7:0] fr [0:15];
   int fr_len;
   int acks;
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // clock pulses with data released, only around reset
   task automatic pulse(input int n);
      repeat (n) begin
         #80 scl_out = 1'b0;
         #80 scl_out = 1'b1;
      end
   endtask : pulse
   // data moves only while clock is low, held past the rise
   task automatic slot(input logic b, output logic s);
      #40 scl_out = 1'b0;
      #40 sda_out = b;
      #40 scl_out = 1'b1;
      s = sda_in;
      #40;
   endtask : slot
   // start, bytes msb first, stop; a refused byte ends the frame
   task automatic run_frame();
      logic s;
      acks = 0;
      sda_out = 1'b0;
      for (int i = 0; i < fr_len; i++) begin
         for (int b = 7; b >= 0; b--) slot(fr[i][b], s);
         slot(1'b1, s);
         if (s !== 1'b0) break;
         acks++;
      end
      slot(1'b0, s);
      #40 sda_out = 1'b1;
      #40;
   endtask : run_frame
endmodule : clkcfg_host_model

// ### test_clock_output_config_bank.sv
// top testbench of the configuration bank
// assumes the host model drives the link; read-back through the index port
`timescale 1ns/1ps
module test_clock_output_config_bank;
   import clkcfg_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mode, fsel, mult, rd_pend, seen;
   logic [2:0] idx;
   logic [7:0] rdat;
   logic [7:0] exp_r [0:6];
   logic [7:0] exp_q [$];
   logic [7:0] wm [0:6] = '{8'ha8, 8'h47, 8'h7f, 8'hff, 8'h3f, 8'h3f, 8'h00};
   logic [23:0] bad_tbl [0:4] = '{24'hd30001, 24'hd40001, 24'hd20101, 24'hd20000, 24'hd20021};
   int bad_ack [0:4] = '{0, 0, 1, 2, 2};
   clkcfg_ctl_t ctl;
   wire logic scl, sda_h, sda_oe, sda_o;
   wire logic sda_w = sda_h & ~(sda_oe & ~sda_o);
   int bad_count, tests_run, n;
   integer seed = 32'h11b0;
   always #20 clk = ~clk;
   clkcfg_bank #(.REVISION_CODE(4'ha), .VENDOR_CODE(4'h6)) dut_u ( // arbitrary id values
      .CLK_SYS_IN(clk), .RESET_IN(rst), .SMB_CLK_IN(scl), .SMB_DATA_IN(sda_w),
      .SMB_DATA_OUT(sda_o), .SMB_DATA_OE_OUT(sda_oe), .TRI_LEVEL_MODE_STRAP_IN(mode),
      .FREQUENCY_SELECT_STRAP_IN(fsel), .CURRENT_MULTIPLIER_STRAP_IN(mult),
      .READ_IDX_IN(idx), .READ_DATA_OUT(rdat), .CTL_OUT(ctl));
   clkcfg_host_model host_u (.scl_out(scl), .sda_out(sda_h), .sda_in(sda_w));
   // scoreboard: oldest note against the byte one cycle after its index
   always @(posedge clk) begin
      seen <= rd_pend;
      if (seen) begin
         tests_run++;
         if (exp_q.size() == 0 || rdat !== exp_q[0]) begin
            $display("[ERR] %0t read-back mismatch", $time);
            bad_count++;
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic rd(input int i, input logic [7:0] e);
      @(posedge clk);
      idx <= i[2:0];
      rd_pend <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_pend <= 1'b0;
   endtask : rd
   // unmapped index first, byte zero last so it stays selected
   task automatic chk_all();
      repeat (10) @(posedge clk);
      rd(7, 8'h00);
      for (int i = 1; i <= 7; i++) rd(i % 7, exp_r[i % 7]);
   endtask : chk_all
   // link needs clock edges during reset, so the host pulses idle clocks
   task automatic do_reset();
      rst <= 1'b1;
      fork
         repeat (16) @(posedge clk);
         host_u.pulse(4);
      join
      @(posedge clk);
      rst <= 1'b0;
      host_u.pulse(3);
      exp_r = '{8'h19 | {5'h0, mode, fsel, 1'b0}, 8'h47 | {mult, 7'h0}, 8'h7f, 8'hc7,
                8'h3f, 8'h00, 8'ha6};
   endtask : do_reset
   // only acked bytes change the expected image, read-only bits masked
   task automatic frame(input logic [7:0] a, c, cnt, input int nd, ex);
      logic [7:0] d;
      host_u.fr[0] = a;
      host_u.fr[1] = c;
      host_u.fr[2] = cnt;
      for (int i = 0; i < nd; i++) begin
         d = 8'($random(seed));
         if (i == 1) d = d & 8'hc7;
         if (i == 4) d = d | 8'h08;
         host_u.fr[3 + i] = d;
         if (ex > 3 + i && i < 7) exp_r[i] = (exp_r[i] & ~wm[i]) | (d & wm[i]);
      end
      host_u.fr_len = 3 + nd;
      host_u.run_frame();
      tests_run++;
      if (host_u.acks != ex) begin
         $display("[ERR] %0t ack count %0d", $time, host_u.acks);
         bad_count++;
      end
      chk_all();
   endtask : frame
   initial begin
      #2ms;
      bad_count++;
      $display("[ERR] %0t run did not finish", $time);
      give_verdict();
   end
   initial begin
      idx = 3'h0;
      rd_pend = 1'b0;
      seen = 1'b0;
      bad_count = 0;
      tests_run = 0;
      {mode, fsel, mult} = 3'($random(seed));
      do_reset();
      chk_all();
      @(posedge clk);
      {mode, fsel, mult} <= ~{mode, fsel, mult};
      chk_all();
      frame(8'hd2, 8'h00, 8'h09, 9, 12);
      frame(8'hd2, 8'h00, 8'h02, 3, 5);
      for (int k = 0; k < 5; k++) begin
         frame(bad_tbl[k][23:16], bad_tbl[k][15:8], bad_tbl[k][7:0], 1, bad_ack[k]);
      end
      repeat (3) begin
         n = 1 + ($random(seed) & 7);
         frame(8'hd2, 8'h00, n[7:0], n, 3 + n);
      end
      do_reset();
      chk_all();
      give_verdict();
   end
endmodule : test_clock_output_config_bank
